// file: design/bit_sync.sv
// Multi-stage synchroniser for levels and toggles
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
   parameter int STAGES = 2,
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic en,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   if (STAGES < 2) begin : g_bad_stages
      $error("bit_sync needs at least two stages");
   end

   logic [STAGES-1:0][W-1:0] chain_q; // Stage zero is read only by stage one

   // Shift chain, frozen while the enable is low
   always_ff @(posedge clk) begin
      if (rst) begin
         chain_q <= '0;
      end else if (en) begin
         chain_q <= {chain_q[STAGES-2:0], d};
      end
   end

   assign q = chain_q[STAGES-1];
endmodule
`default_nettype wire

// file: design/serial_port_cfg_pkg.sv
// Constants and types shared by the serial port configuration block
package serial_port_cfg_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam int ADDR_W = 13;                                   // Address field width
   localparam logic [ADDR_W-1:0] OFS_SERIAL_PORT_CONFIG = 13'h000; // Pin usage, bit order, reset
   localparam logic [ADDR_W-1:0] OFS_READBACK_SELECT = 13'h004;    // Active or buffered readback
   localparam logic [ADDR_W-1:0] OFS_USER_VERSION_ID_LOW = 13'h005;  // Version ID bits 7:0
   localparam logic [ADDR_W-1:0] OFS_USER_VERSION_ID_HIGH = 13'h006; // Version ID bits 15:8

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CFG_PIN_USAGE_BIT = 7;   // 1: reads leave on the serial output pin
   localparam int CFG_LSB_FIRST_BIT = 6;   // 1: LSB first, address increments
   localparam int CFG_SOFT_RESET_BIT = 5;  // Self-clearing soft reset
   localparam int CFG_MIRROR_LSB_BIT = 1;  // Mirror of the bit-order bit
   localparam int CFG_MIRROR_PIN_BIT = 0;  // Mirror of the pin-usage bit
   localparam int RBSEL_BIT = 0;           // Readback select bit
   localparam int INSTR_RW_BIT = 15;       // 1: read, in the instruction word

   // ---------------------------------------------------------------
   // Reset values and frame counts
   // ---------------------------------------------------------------
   localparam logic [7:0] BYTE_ZERO = 8'h00;             // Unmapped reads and reserved bits
   localparam logic [15:0] VERSION_ID_DEFAULT = 16'h0000; // Version ID after reset
   localparam logic [3:0] INSTR_LAST = 4'hf;             // Last bit of the 16-bit instruction
   localparam logic [3:0] BYTE_LAST = 4'h7;              // Last bit of a data byte
   localparam logic [3:0] CNT_STEP = 4'h1;               // Bit counter increment
   localparam logic [ADDR_W-1:0] ADDR_STEP = 13'h0001;   // Address step per byte

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic {
      PH_INSTR,
      PH_DATA
   } phase_t;

   // Readback image handed from the core clock to the serial clock
   typedef struct packed {
      logic use_out_pin;   // Effective pin usage, forced off in two-wire mode
      logic lsb_first;     // Effective bit order, forced off in two-wire mode
      logic [7:0] cfg;     // Readback of the port configuration register
      logic [7:0] rbsel;   // Readback of the readback select register
      logic [7:0] vid_lo;  // Version ID low byte as selected for readback
      logic [7:0] vid_hi;  // Version ID high byte as selected for readback
   } image_t;

   // Core clock state
   typedef struct packed {
      logic pin_usage_select;  // Stored pin-usage bit
      logic lsb_first;         // Stored bit-order bit
      logic rbsel;             // Readback select
      logic [15:0] vid_pend;   // Buffered version ID
      logic [15:0] vid_act;    // Active version ID
      logic wr_seen;           // Last seen write toggle
      logic upd_seen;          // Last seen update strobe level
      image_t img;             // Published readback image
      logic img_req;           // Image handshake request toggle
      logic srst;              // Soft reset pulse
   } core_t;

   // Serial clock state living for one frame
   typedef struct packed {
      phase_t phase;                // Instruction or data phase
      logic [3:0] cnt;              // Bit counter inside phase
      logic [15:0] shreg;           // Receive shift register
      logic is_read;                // Frame direction
      logic [ADDR_W-1:0] addr;      // Current register address
      logic [7:0] rd_byte;          // Byte being sent
   } frame_t;

   // Serial clock state living across frames
   typedef struct packed {
      logic wr_tgl;                 // Write event toggle
      logic [ADDR_W-1:0] wr_addr;   // Held write address
      logic [7:0] wr_data;          // Held write data
      logic ack;                    // Image handshake acknowledge
      image_t img;                  // Local copy of readback image
   } link_t;

   localparam core_t CORE_RESET = '0;  // All registers at their defaults
   localparam frame_t FRAME_RESET = '0; // Idle frame
   localparam link_t LINK_RESET = '0;   // Empty link state

endpackage

// file: design/serial_port_config_regs.sv
// Serial port configuration registers with their serial shift engine
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Pin-usage bit zero: reads return on data pin
// - Pin-usage bit one: reads leave on output pin
// - Bit-order zero: MSB first, address decrements
// - Bit-order one: LSB first, address increments
// - Two-wire mode ignores pin-usage and bit-order bits
// - Soft reset bit restores defaults, self-clears
// - Readback select zero returns active values
// - Readback select one returns buffered values
// - Sixteen-bit version ID, two bytes, reset zero
// - Version ID affects nothing else
module serial_port_config_regs
   import serial_port_cfg_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic I2C_MODE,
   input wire logic UPDATE,
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic SDIO_I,
   output logic SDIO_O,
   output logic SDIO_OE,
   output logic SERIAL_OUT_PIN_O,
   output logic SERIAL_OUT_PIN_OE,
   output logic [15:0] ACTIVE_VERSION_ID,
   output logic SOFT_RESET_PULSE
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   core_t core_q;          // Core clock registers
   core_t core_d;          // Next core state
   frame_t fr_q;           // Per-frame serial state
   frame_t fr_d;           // Next per-frame state
   link_t lk_q;            // Cross-frame serial state
   link_t lk_d;            // Next cross-frame state
   logic out_q;            // Outgoing data bit, launched on falling edge

   // ---------------------------------------------------------------
   // Crossings
   // ---------------------------------------------------------------
   logic wr_s;             // Write toggle seen in core clock
   logic ack_s;            // Image acknowledge seen in core clock
   logic i2c_s;            // Two-wire mode level
   logic upd_s;            // Update strobe level
   logic req_s;            // Image request seen in serial clock

   // Write toggle into the core clock
   bit_sync #(.STAGES(2), .W(1)) u_wr_sync (
      .clk(CLK),
      .rst(RST),
      .en(CE),
      .d(lk_q.wr_tgl),
      .q(wr_s)
   );

   // Image acknowledge back into the core clock
   bit_sync #(.STAGES(2), .W(1)) u_ack_sync (
      .clk(CLK),
      .rst(RST),
      .en(CE),
      .d(lk_q.ack),
      .q(ack_s)
   );

   // Mode pin, a quasi-static level
   bit_sync #(.STAGES(2), .W(1)) u_i2c_sync (
      .clk(CLK),
      .rst(RST),
      .en(CE),
      .d(I2C_MODE),
      .q(i2c_s)
   );

   // Register update strobe pin
   bit_sync #(.STAGES(2), .W(1)) u_upd_sync (
      .clk(CLK),
      .rst(RST),
      .en(CE),
      .d(UPDATE),
      .q(upd_s)
   );

   // Image request into the serial clock; it settles within two edges,
   // so no reset is needed in a domain whose clock may stand still
   bit_sync #(.STAGES(2), .W(1)) u_req_sync (
      .clk(SCLK),
      .rst(1'b0),
      .en(1'b1),
      .d(core_q.img_req),
      .q(req_s)
   );

   // ---------------------------------------------------------------
   // Core clock register file
   // ---------------------------------------------------------------
   logic wr_evt;           // A serial write byte has landed
   logic upd_evt;          // Rising edge of the update strobe
   logic soft_rst;         // Soft reset requested by this write
   image_t live;           // Readback image from current registers

   assign wr_evt = (wr_s != core_q.wr_seen);
   assign upd_evt = upd_s & ~core_q.upd_seen;

   // Next-state of the register file
   always_comb begin
      core_d = core_q;
      core_d.srst = 1'b0;
      core_d.wr_seen = wr_s;
      core_d.upd_seen = upd_s;
      soft_rst = 1'b0;
      // Held address and data are stable while the toggle is in flight
      if (wr_evt) begin
         case (lk_q.wr_addr)
            OFS_SERIAL_PORT_CONFIG: begin
               // Only bits 7:5 are decoded; the mirror bits are not needed
               if (lk_q.wr_data[CFG_SOFT_RESET_BIT]) begin
                  soft_rst = 1'b1;
               end else begin
                  core_d.pin_usage_select = lk_q.wr_data[CFG_PIN_USAGE_BIT];
                  core_d.lsb_first = lk_q.wr_data[CFG_LSB_FIRST_BIT];
               end
            end
            OFS_READBACK_SELECT: begin
               core_d.rbsel = lk_q.wr_data[RBSEL_BIT];
            end
            OFS_USER_VERSION_ID_LOW: begin
               core_d.vid_pend[7:0] = lk_q.wr_data;
            end
            OFS_USER_VERSION_ID_HIGH: begin
               core_d.vid_pend[15:8] = lk_q.wr_data;
            end
            default: begin
               // Unmapped writes are dropped
            end
         endcase
      end
      // Buffered value goes live on the update strobe
      if (upd_evt) begin
         core_d.vid_act = core_d.vid_pend;
      end
      // Soft reset wins over every other change in the same cycle
      if (soft_rst) begin
         core_d.pin_usage_select = 1'b0;
         core_d.lsb_first = 1'b0;
         core_d.rbsel = 1'b0;
         core_d.vid_pend = VERSION_ID_DEFAULT;
         core_d.vid_act = VERSION_ID_DEFAULT;
         core_d.srst = 1'b1;
      end
      // Publish a new image only when the previous one was taken
      if ((ack_s == core_q.img_req) && (live != core_q.img)) begin
         core_d.img = live;
         core_d.img_req = ~core_q.img_req;
      end
   end

   // Readback image built from registered values
   always_comb begin
      live.use_out_pin = core_q.pin_usage_select & ~i2c_s;
      live.lsb_first = core_q.lsb_first & ~i2c_s;
      live.cfg = BYTE_ZERO;
      live.cfg[CFG_PIN_USAGE_BIT] = core_q.pin_usage_select;
      live.cfg[CFG_LSB_FIRST_BIT] = core_q.lsb_first;
      live.cfg[CFG_MIRROR_PIN_BIT] = core_q.pin_usage_select;
      live.cfg[CFG_MIRROR_LSB_BIT] = core_q.lsb_first;
      live.rbsel = BYTE_ZERO;
      live.rbsel[RBSEL_BIT] = core_q.rbsel;
      // Pending or active copy, as software asked
      if (core_q.rbsel) begin
         live.vid_lo = core_q.vid_pend[7:0];
         live.vid_hi = core_q.vid_pend[15:8];
      end else begin
         live.vid_lo = core_q.vid_act[7:0];
         live.vid_hi = core_q.vid_act[15:8];
      end
   end

   // Core register stage, frozen while the enable is low
   always_ff @(posedge CLK) begin
      if (RST) begin
         core_q <= CORE_RESET;
      end else if (CE) begin
         core_q <= core_d;
      end
   end

   // The version ID only leaves as a plain output, steering nothing
   assign ACTIVE_VERSION_ID = core_q.vid_act;
   assign SOFT_RESET_PULSE = core_q.srst;

   // ---------------------------------------------------------------
   // Serial clock shift engine
   // ---------------------------------------------------------------
   logic [15:0] sh_next;          // Shift register with the new bit
   logic [15:0] instr;            // Instruction in register order
   logic [7:0] byte_in;           // Received byte in register order
   logic [ADDR_W-1:0] addr_next;  // Address for the next byte
   logic drv;                     // Read data is on the wire

   // Register read mux over the local image
   function automatic logic [7:0] read_byte(input logic [ADDR_W-1:0] a, input image_t im);
      logic [7:0] r;
      r = BYTE_ZERO;
      case (a)
         OFS_SERIAL_PORT_CONFIG: r = im.cfg;
         OFS_READBACK_SELECT: r = im.rbsel;
         OFS_USER_VERSION_ID_LOW: r = im.vid_lo;
         OFS_USER_VERSION_ID_HIGH: r = im.vid_hi;
         default: r = BYTE_ZERO;
      endcase
      return r;
   endfunction

   // Next-state of the shift engine
   always_comb begin
      fr_d = fr_q;
      lk_d = lk_q;
      sh_next = {fr_q.shreg[14:0], SDIO_I};
      // LSB-first frames arrive bit-reversed
      instr = lk_q.img.lsb_first ? 16'({<<{sh_next}}) : sh_next;
      byte_in = lk_q.img.lsb_first ? 8'({<<{sh_next[7:0]}}) : sh_next[7:0];
      // Step direction follows the bit order
      if (lk_q.img.lsb_first) begin
         addr_next = ADDR_W'(fr_q.addr + ADDR_STEP);
      end else begin
         addr_next = ADDR_W'(fr_q.addr - ADDR_STEP);
      end
      // Take a newly published image
      if (req_s != lk_q.ack) begin
         lk_d.img = core_q.img;
         lk_d.ack = req_s;
      end
      fr_d.shreg = sh_next;
      fr_d.cnt = 4'(fr_q.cnt + CNT_STEP);
      case (fr_q.phase)
         PH_INSTR: begin
            // Instruction complete: direction and start address
            if (fr_q.cnt == INSTR_LAST) begin
               fr_d.phase = PH_DATA;
               fr_d.cnt = '0;
               fr_d.is_read = instr[INSTR_RW_BIT];
               fr_d.addr = instr[ADDR_W-1:0];
               fr_d.rd_byte = read_byte(instr[ADDR_W-1:0], lk_q.img);
            end
         end
         PH_DATA: begin
            // Byte complete: hand a write over, then step the address
            if (fr_q.cnt == BYTE_LAST) begin
               fr_d.cnt = '0;
               if (!fr_q.is_read) begin
                  lk_d.wr_addr = fr_q.addr;
                  lk_d.wr_data = byte_in;
                  lk_d.wr_tgl = ~lk_q.wr_tgl;
               end
               fr_d.addr = addr_next;
               fr_d.rd_byte = read_byte(addr_next, lk_q.img);
            end
         end
         default: begin
            fr_d.phase = PH_INSTR;
         end
      endcase
   end

   // Frame state, cleared whenever chip select is high
   always_ff @(posedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         fr_q <= FRAME_RESET;
      end else begin
         fr_q <= fr_d;
      end
   end

   // Cross-frame state; reset is expected while the serial clock idles
   always_ff @(posedge SCLK or posedge RST) begin
      if (RST) begin
         lk_q <= LINK_RESET;
      end else begin
         lk_q <= lk_d;
      end
   end

   // Launch each read bit on the falling edge so the host samples it
   // cleanly on the next rising edge
   always_ff @(negedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         out_q <= 1'b0;
      end else if (lk_q.img.lsb_first) begin
         out_q <= fr_q.rd_byte[fr_q.cnt[2:0]];
      end else begin
         out_q <= fr_q.rd_byte[~fr_q.cnt[2:0]];
      end
   end

   // ---------------------------------------------------------------
   // Pin drivers
   // ---------------------------------------------------------------
   assign drv = (fr_q.phase == PH_DATA) & fr_q.is_read & ~CS_N;
   assign SDIO_OE = drv & ~lk_q.img.use_out_pin;
   assign SERIAL_OUT_PIN_OE = drv & lk_q.img.use_out_pin;
   assign SDIO_O = out_q;
   assign SERIAL_OUT_PIN_O = out_q;

endmodule
`default_nettype wire

// file: sim/serial_host_model.sv
// Behavioural serial host that frames reads and writes
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
   output logic SCLK,
   output logic CS_N,
   output logic SDIO_I,
   input wire logic SDIO_O,
   input wire logic SDIO_OE,
   input wire logic SERIAL_OUT_PIN_O,
   input wire logic SERIAL_OUT_PIN_OE
);
   logic host_oe; // Host drives the data pin
   logic host_d; // Level the host drives
   logic junk; // Toggles so a released line never shows its last bit
   logic saw_sdio; // Device drove the data pin this frame
   logic saw_pin; // Device drove the output pin this frame
   // Clock idles low and stands still between frames
   initial begin
      SCLK = 1'b0;
      CS_N = 1'b0;
      host_oe = 1'b1;
      host_d = 1'b0;
      junk = 1'b0;
      // Deselect after time zero so frame flops see a true edge
      #1 CS_N = 1'b1;
   end
   always @(posedge SCLK) junk <= ~junk;
   // Wire level: device first, then host, else a moving pattern
   assign SDIO_I = SDIO_OE ? SDIO_O : (host_oe ? host_d : junk);
   // One frame: instruction, then n data bytes, 15 ns clock
   task automatic frame(input logic rd, input logic [12:0] a, input logic lsb, input logic pin,
                        input int n, input logic [7:0] wd, output logic [15:0] rdat);
      logic [15:0] ins;
      int p;
      ins = {rd, 2'b11, a};
      rdat = 16'h0000;
      saw_sdio = 1'b0;
      saw_pin = 1'b0;
      #3 CS_N = 1'b0;
      for (int i = 0; i < 16 + 8 * n; i++) begin
         p = lsb ? (i % 8) : (7 - i % 8);
         if (i < 16) host_d = lsb ? ins[i] : ins[15 - i];
         else if (!rd) host_d = wd[p];
         else host_oe = 1'b0;
         #7.5 SCLK = 1'b1;
         saw_sdio |= SDIO_OE;
         saw_pin |= SERIAL_OUT_PIN_OE;
         if (rd && i >= 16) begin
            rdat[(n - 1 - (i - 16) / 8) * 8 + p] =
               pin ? (SERIAL_OUT_PIN_OE ? SERIAL_OUT_PIN_O : junk) : SDIO_I;
         end
         #7.5 SCLK = 1'b0;
      end
      #7.5 CS_N = 1'b1;
      host_oe = 1'b1;
      host_d = ~host_d;
   endtask
endmodule
`default_nettype wire

// file: sim/serial_port_config_regs_properties.sv
// Concurrent checks on the configuration port pins
`timescale 1ns/1ps
`default_nettype none
module serial_port_config_regs_properties (
   input wire logic CLK,
   input wire logic RST,
   input wire logic UPDATE,
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic SDIO_OE,
   input wire logic SERIAL_OUT_PIN_OE,
   input wire logic [15:0] ACTIVE_VERSION_ID,
   input wire logic SOFT_RESET_PULSE
);
   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   logic [2:0] upd_age_q; // Cycles since UPDATE was high, saturating
   logic [4:0] edge_cnt_q; // Rising SCLK edges in this frame
   // Saturates so a long quiet spell never wraps back into range
   always_ff @(posedge CLK) begin
      if (RST) upd_age_q <= 3'h7;
      else if (UPDATE) upd_age_q <= 3'h0;
      else if (upd_age_q != 3'h7) upd_age_q <= upd_age_q + 3'h1;
   end
   // Frame edge count, cleared while deselected
   always_ff @(posedge SCLK or posedge CS_N) begin
      if (CS_N) edge_cnt_q <= 5'h00;
      else if (edge_cnt_q != 5'h1f) edge_cnt_q <= edge_cnt_q + 5'h01;
   end
   // ----------------------------------------
   // Sequences and assertions
   // ----------------------------------------
   sequence pulse_s;
      SOFT_RESET_PULSE;
   endsequence
   sequence quiet_s;
      !UPDATE [*4];
   endsequence
   AST_OE_EXCLUSIVE: assert property (@(posedge CLK) disable iff (RST)
      !(SDIO_OE && SERIAL_OUT_PIN_OE)) else $error("both data outputs enabled");
   AST_IDLE_UNDRIVEN: assert property (@(posedge CLK) disable iff (RST)
      CS_N |-> !SDIO_OE && !SERIAL_OUT_PIN_OE) else $error("output driven while deselected");
   AST_INSTR_QUIET: assert property (@(posedge SCLK) disable iff (RST)
      edge_cnt_q < 5'h10 |-> !SDIO_OE && !SERIAL_OUT_PIN_OE) else $error("drive in instruction");
   AST_PULSE_ONE: assert property (@(posedge CLK) disable iff (RST)
      pulse_s |=> !SOFT_RESET_PULSE) else $error("soft reset pulse too long");
   AST_PULSE_DEFAULT: assert property (@(posedge CLK) disable iff (RST)
      pulse_s |-> ACTIVE_VERSION_ID == 16'h0000) else $error("version not cleared");
   AST_PULSE_HOLD: assert property (@(posedge CLK) disable iff (RST)
      pulse_s ##1 quiet_s |-> ACTIVE_VERSION_ID == 16'h0000) else $error("version not held");
   AST_UPDATE_CAUSE: assert property (@(posedge CLK) disable iff (RST)
      $changed(ACTIVE_VERSION_ID) && !SOFT_RESET_PULSE |-> upd_age_q != 3'h7)
      else $error("active version changed without update");
   AST_RESET_VALUES: assert property (@(posedge CLK) disable iff (RST)
      $fell(RST) |-> ACTIVE_VERSION_ID == 16'h0000 && !SOFT_RESET_PULSE)
      else $error("wrong values after reset");
endmodule
bind serial_port_config_regs serial_port_config_regs_properties chk (
   .CLK(CLK),
   .RST(RST),
   .UPDATE(UPDATE),
   .SCLK(SCLK),
   .CS_N(CS_N),
   .SDIO_OE(SDIO_OE),
   .SERIAL_OUT_PIN_OE(SERIAL_OUT_PIN_OE),
   .ACTIVE_VERSION_ID(ACTIVE_VERSION_ID),
   .SOFT_RESET_PULSE(SOFT_RESET_PULSE)
);
`default_nettype wire

// file: sim/test_serial_port_config_regs.sv
// Self-checking bench for the serial port configuration registers
`timescale 1ns/1ps
`default_nettype none
module test_serial_port_config_regs
   import serial_port_cfg_pkg::*;
;
   logic CLK, RST, CE, I2C_MODE, UPDATE; // Core side inputs
   logic SCLK, CS_N, SDIO_I, SDIO_O, SDIO_OE; // Serial pins
   logic SERIAL_OUT_PIN_O, SERIAL_OUT_PIN_OE, SOFT_RESET_PULSE;
   logic [15:0] ACTIVE_VERSION_ID;
   int mismatches, tests_run, pulses; // Counters
   logic [15:0] rd, vid, exp_act; // Read data and expectations
   logic lsb, pin; // Mode the host speaks in
   always #50 CLK = ~CLK;
   serial_port_config_regs uut (.CLK(CLK), .RST(RST), .CE(CE), .I2C_MODE(I2C_MODE),
      .UPDATE(UPDATE), .SCLK(SCLK), .CS_N(CS_N), .SDIO_I(SDIO_I), .SDIO_O(SDIO_O),
      .SDIO_OE(SDIO_OE), .SERIAL_OUT_PIN_O(SERIAL_OUT_PIN_O),
      .SERIAL_OUT_PIN_OE(SERIAL_OUT_PIN_OE), .ACTIVE_VERSION_ID(ACTIVE_VERSION_ID),
      .SOFT_RESET_PULSE(SOFT_RESET_PULSE));
   serial_host_model host (.SCLK(SCLK), .CS_N(CS_N), .SDIO_I(SDIO_I), .SDIO_O(SDIO_O),
      .SDIO_OE(SDIO_OE), .SERIAL_OUT_PIN_O(SERIAL_OUT_PIN_O),
      .SERIAL_OUT_PIN_OE(SERIAL_OUT_PIN_OE));
   // Count soft reset pulses as they pass
   always @(posedge CLK) if (SOFT_RESET_PULSE === 1'b1) pulses++;
   // ----------------------------------------
   // Expectations and helpers
   // ----------------------------------------
   function automatic logic [7:0] cfg_byte(input logic p, input logic l, input logic s);
      return {p, l, s, 1'b0, 1'b0, s, l, p};
   endfunction
   // Reset bit and reserved bits read zero
   function automatic logic [15:0] cfg_read(input logic p, input logic l);
      return {8'h00, p, l, 4'h0, l, p};
   endfunction
   task automatic results;
      if (mismatches == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Settle one step past the edge so registered outputs are seen
   task automatic idle(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   // Writes are one byte a frame, spaced well apart for the crossing
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      host.frame(1'b0, a, lsb, pin, 1, d, rd);
      idle(12);
   endtask
   task automatic rdn(input logic [12:0] a, input int n, input logic [15:0] exp);
      host.frame(1'b1, a, lsb, pin, n, 8'h00, rd);
      cmp(rd, exp);
      idle(2);
   endtask
   // Hang guard: a run past its bound fails
   initial begin
      repeat (20000) @(posedge CLK);
      mismatches++;
      results();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      CLK = 1'b0;
      RST = 1'b0;
      CE = 1'b1;
      I2C_MODE = 1'b0;
      UPDATE = 1'b0;
      {lsb, pin, mismatches, tests_run, pulses, exp_act} = '0;
      vid = 16'($urandom(32'h2e3d91cc));
      // Raised after time zero so the link flops see a true edge
      #1 RST = 1'b1;
      repeat (8) @(posedge CLK);
      RST <= 1'b0;
      idle(6);
      rdn(OFS_SERIAL_PORT_CONFIG, 1, 16'h0000);
      rdn(OFS_READBACK_SELECT, 1, 16'h0000);
      rdn(OFS_USER_VERSION_ID_HIGH, 2, 16'h0000);
      // Random IDs: active view, buffered view, then update
      repeat (2) begin
         vid = 16'($urandom);
         wr(OFS_USER_VERSION_ID_LOW, vid[7:0]);
         wr(OFS_USER_VERSION_ID_HIGH, vid[15:8]);
         rdn(OFS_USER_VERSION_ID_HIGH, 2, exp_act);
         wr(OFS_READBACK_SELECT, 8'h01);
         rdn(OFS_USER_VERSION_ID_HIGH, 2, vid);
         cmp(ACTIVE_VERSION_ID, exp_act);
         // A strobe that comes and goes while the enable is low is lost
         @(posedge CLK) CE <= 1'b0;
         @(posedge CLK) UPDATE <= 1'b1;
         @(posedge CLK) UPDATE <= 1'b0;
         idle(4);
         @(posedge CLK) CE <= 1'b1;
         idle(8);
         cmp(ACTIVE_VERSION_ID, exp_act);
         @(posedge CLK) UPDATE <= 1'b1;
         @(posedge CLK) UPDATE <= 1'b0;
         idle(8);
         exp_act = vid;
         cmp(ACTIVE_VERSION_ID, exp_act);
         wr(OFS_READBACK_SELECT, 8'h00);
      end
      // LSB first; the unmapped all-ones read is order-proof
      wr(OFS_SERIAL_PORT_CONFIG, cfg_byte(1'b0, 1'b1, 1'b0));
      lsb = 1'b1;
      rdn(13'h1fff, 1, 16'h0000);
      rdn(OFS_SERIAL_PORT_CONFIG, 1, cfg_read(1'b0, 1'b1));
      rdn(OFS_USER_VERSION_ID_LOW, 2, {vid[7:0], vid[15:8]});
      // Reads move to the dedicated output pin
      wr(OFS_SERIAL_PORT_CONFIG, cfg_byte(1'b1, 1'b1, 1'b0));
      pin = 1'b1;
      rdn(13'h1fff, 1, 16'h0000);
      rdn(OFS_SERIAL_PORT_CONFIG, 1, cfg_read(1'b1, 1'b1));
      cmp({14'h0000, host.saw_pin, host.saw_sdio}, 16'h0002);
      // Two-wire mode forces MSB first on the data pin
      @(posedge CLK) I2C_MODE <= 1'b1;
      idle(6);
      {lsb, pin} = 2'b00;
      rdn(13'h1fff, 1, 16'h0000);
      rdn(OFS_USER_VERSION_ID_HIGH, 2, vid);
      cmp({14'h0000, host.saw_pin, host.saw_sdio}, 16'h0001);
      @(posedge CLK) I2C_MODE <= 1'b0;
      idle(6);
      {lsb, pin} = 2'b11;
      rdn(13'h1fff, 1, 16'h0000);
      // Soft reset brings everything back to defaults
      wr(OFS_SERIAL_PORT_CONFIG, cfg_byte(1'b1, 1'b1, 1'b1));
      cmp(16'(pulses), 16'h0001);
      cmp(ACTIVE_VERSION_ID, 16'h0000);
      {lsb, pin} = 2'b00;
      rdn(13'h1fff, 1, 16'h0000);
      rdn(OFS_SERIAL_PORT_CONFIG, 1, 16'h0000);
      rdn(OFS_READBACK_SELECT, 1, 16'h0000);
      rdn(OFS_USER_VERSION_ID_HIGH, 2, 16'h0000);
      results();
   end
endmodule
`default_nettype wire
